// ### hdl/tor_pkg.sv
/*
  Shared constants and carrier types of the trigger output router: command codes,
  output counts, pulse timing and the invalid-measurement sentinel.
  Assumes a single 25 MHz clock domain and a command source that issues one command
  at a time.
*/
package tor_pkg;

  // Output counts.
  localparam int TTL_LINES = 8;
  localparam int ECL_LINES = 2;

  // Clock and pulse timing; a least time rounds up to whole cycles.
  localparam int CLK_NS = 40;
  localparam int PULSE_NS = 200;
  localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] PULSE_LOAD = CNT_W'(PULSE_CYC - 1);

  // Response word values.
  localparam logic [31:0] RESP_ON = 32'h0000_0001;
  localparam logic [31:0] RESP_OFF = 32'h0000_0000;
  // Single-precision encoding of 9.99999E+37, returned for an invalid measurement.
  localparam logic [31:0] SENTINEL = 32'h7e96_768f;

  // Command codes.
  localparam logic [3:0] OP_NONE = 4'h0;
  localparam logic [3:0] OP_SET_MASTER = 4'h1;
  localparam logic [3:0] OP_SET_TTL = 4'h2;
  localparam logic [3:0] OP_SET_ECL = 4'h3;
  localparam logic [3:0] OP_SET_EXT = 4'h4;
  localparam logic [3:0] OP_QRY_MASTER = 4'h5;
  localparam logic [3:0] OP_QRY_TTL = 4'h6;
  localparam logic [3:0] OP_QRY_ECL = 4'h7;
  localparam logic [3:0] OP_QRY_EXT = 4'h8;
  localparam logic [3:0] OP_START = 4'h9;
  localparam logic [3:0] OP_FETCH = 4'ha;
  localparam logic [3:0] OP_READ = 4'hb;

  // One command word.
  typedef struct packed {
    logic [3:0] op;
    logic [2:0] idx;
    logic value;
    logic has_func;
  } tor_cmd_s;

  // Measurement sequencer states.
  typedef enum logic [1:0] {
    MS_IDLE = 2'b00,
    MS_WAIT = 2'b01
  } tor_meas_e;

endpackage

// ### hdl/tor_pulse.sv
/*
  Non-retriggerable one-shot that times every trigger output pulse.
  Assumes the caller gates the fire input with its own clock enable context.
*/
`timescale 1ns/100ps
module tor_pulse import tor_pkg::*; (
  // Clock, reset and clock enable.
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Trigger in, pulse window out.
  input wire logic fire,
  output logic active
);

  logic [CNT_W-1:0] count_q;
  logic active_q;

  // A trigger during a pulse is ignored so the pulse is never stretched or split.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_q <= '0;
      active_q <= 1'b0;
    end else if (ce) begin
      if (fire && !active_q) begin
        count_q <= PULSE_LOAD;
        active_q <= 1'b1;
      end else if (count_q != '0) begin
        count_q <= count_q - CNT_W'(1);
      end else begin
        active_q <= 1'b0;
      end
    end
  end

  assign active = active_q;

endmodule // tor_pulse

// ### hdl/tor_router.sv
/*
  Trigger output router: enables, trigger pulse outputs, enable queries and the
  read-measurement sequencer feeding the response buffer.
  Assumes commands and measurement handshakes are synchronous to CLK, and that the
  response buffer downstream honours the flush strobe before the next word.
*/
// Overview of operation
// - Master enable off blocks every trigger output.
// - Master enable query answers on or off.
// - Each TTL line has its own enable.
// - Enabled TTL lines pulse on each trigger that arrives outside a pulse.
// - TTL pulses go low from high idle.
// - All outputs may be enabled together.
// - Output pulses only with both enables set.
// - TTL line enable query answers on/off.
// - Instrument reset clears all enables.
// - Read starts measurement then fetches result.
// - Read discards stale response buffer data.
// - Invalid result returns the fixed sentinel.
// - Bare read after reset raises error.
// - Enabled ECL lines pulse active high.
// - Front connector pulses low when enabled.
`timescale 1ns/100ps
module tor_router import tor_pkg::*; (
  // Clock, reset, clock enable.
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  // Command port and instrument reset.
  input wire logic CMD_VALID,
  input wire tor_cmd_s CMD,
  output logic CMD_READY,
  input wire logic SOFT_RST,
  // Internal trigger event.
  input wire logic TRIG_EVENT,
  // Trigger outputs.
  output logic [TTL_LINES-1:0] TTL_N,
  output logic [ECL_LINES-1:0] ECL,
  output logic EXT_N,
  // Enable readback.
  output logic MASTER_EN,
  // Measurement engine handshake.
  output logic MEAS_START,
  input wire logic MEAS_DONE,
  input wire logic MEAS_VALID,
  input wire logic [31:0] MEAS_RESULT,
  // Response buffer.
  output logic RESP_VALID,
  output logic [31:0] RESP_DATA,
  output logic RESP_FLUSH,
  output logic ERR
);

  // Decode a line index to a one-hot mask; used by both set and query paths.
  function automatic logic [TTL_LINES-1:0] line_mask(input logic [2:0] idx);
    line_mask = TTL_LINES'(1) << idx;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Command acceptance.

  logic cmd_take;
  logic master_en_q;
  logic [TTL_LINES-1:0] ttl_en_q;
  logic [ECL_LINES-1:0] ecl_en_q;
  logic ext_en_q;
  logic cmd_ready_q;
  tor_meas_e state_q;

  // Commands are only taken while the sequencer is idle.
  assign cmd_take = CMD_VALID && cmd_ready_q && !SOFT_RST;

  ////////////////////////////////////////////////////////////////////////////////
  // Enable registers.

  // Instrument reset wins over a command in the same cycle.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      master_en_q <= 1'b0;
      ttl_en_q <= '0;
      ecl_en_q <= '0;
      ext_en_q <= 1'b0;
    end else if (CE) begin
      if (SOFT_RST) begin
        master_en_q <= 1'b0;
        ttl_en_q <= '0;
        ecl_en_q <= '0;
        ext_en_q <= 1'b0;
      end else if (cmd_take) begin
        // Each enable is independent, so any combination may be on together.
        case (CMD.op)
          OP_SET_MASTER: master_en_q <= CMD.value;
          OP_SET_TTL: begin
            if (CMD.value) begin
              ttl_en_q <= ttl_en_q | line_mask(CMD.idx);
            end else begin
              ttl_en_q <= ttl_en_q & ~line_mask(CMD.idx);
            end
          end
          OP_SET_ECL: ecl_en_q[CMD.idx[0]] <= CMD.value;
          OP_SET_EXT: ext_en_q <= CMD.value;
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Trigger pulse generation.

  logic pulse_active;
  logic trig_accept;
  logic [TTL_LINES-1:0] ttl_gate_q;
  logic [ECL_LINES-1:0] ecl_gate_q;
  logic ext_gate_q;
  logic [TTL_LINES-1:0] ttl_n_q;
  logic [ECL_LINES-1:0] ecl_q;
  logic ext_n_q;

  assign trig_accept = TRIG_EVENT && !pulse_active;

  tor_pulse u_pulse (
    .clk(CLK),
    .nrst(NRST),
    .ce(CE),
    .fire(TRIG_EVENT),
    .active(pulse_active)
  );

  // The line enables are sampled at the trigger so a line-enable write mid-pulse cannot chop it.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ttl_gate_q <= '0;
      ecl_gate_q <= '0;
      ext_gate_q <= 1'b0;
    end else if (CE && trig_accept) begin
      ttl_gate_q <= ttl_en_q;
      ecl_gate_q <= ecl_en_q;
      ext_gate_q <= ext_en_q;
    end
  end

  // The live master enable still cuts every output at once when it drops.
  genvar gi;
  generate
    for (gi = 0; gi < TTL_LINES; gi++) begin : g_ttl
      always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
          ttl_n_q[gi] <= 1'b1;
        end else if (CE) begin
          ttl_n_q[gi] <= !(pulse_active && ttl_gate_q[gi] && master_en_q);
        end
      end
    end
    for (gi = 0; gi < ECL_LINES; gi++) begin : g_ecl
      always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
          ecl_q[gi] <= 1'b0;
        end else if (CE) begin
          ecl_q[gi] <= pulse_active && ecl_gate_q[gi] && master_en_q;
        end
      end
    end
  endgenerate

  // Front connector idles high and pulses low.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ext_n_q <= 1'b1;
    end else if (CE) begin
      ext_n_q <= !(pulse_active && ext_gate_q && master_en_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Measurement sequencer and response buffer.

  logic deliver_q;
  logic meas_have_q;
  logic result_ok_q;
  logic [31:0] result_q;
  logic meas_start_q;
  logic resp_valid_q;
  logic [31:0] resp_data_q;
  logic resp_flush_q;
  logic err_q;
  logic [31:0] meas_word;

  // An invalid measurement is replaced by the sentinel before it is stored.
  assign meas_word = MEAS_VALID ? MEAS_RESULT : SENTINEL;

  // One process owns the sequencer and every response strobe.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_q <= MS_IDLE;
      cmd_ready_q <= 1'b1;
      deliver_q <= 1'b0;
      meas_have_q <= 1'b0;
      result_ok_q <= 1'b0;
      result_q <= '0;
      meas_start_q <= 1'b0;
      resp_valid_q <= 1'b0;
      resp_data_q <= '0;
      resp_flush_q <= 1'b0;
      err_q <= 1'b0;
    end else if (CE) begin
      meas_start_q <= 1'b0;
      resp_valid_q <= 1'b0;
      resp_flush_q <= 1'b0;
      err_q <= 1'b0;
      if (SOFT_RST) begin
        // Reset forgets the last measurement; a bare read must then fail.
        state_q <= MS_IDLE;
        cmd_ready_q <= 1'b1;
        meas_have_q <= 1'b0;
        result_ok_q <= 1'b0;
      end else begin
        case (state_q)
          MS_IDLE: begin
            if (cmd_take) begin
              case (CMD.op)
                OP_QRY_MASTER: begin
                  resp_valid_q <= 1'b1;
                  resp_data_q <= master_en_q ? RESP_ON : RESP_OFF;
                end
                OP_QRY_TTL: begin
                  resp_valid_q <= 1'b1;
                  resp_data_q <= |(ttl_en_q & line_mask(CMD.idx)) ? RESP_ON : RESP_OFF;
                end
                OP_QRY_ECL: begin
                  resp_valid_q <= 1'b1;
                  resp_data_q <= ecl_en_q[CMD.idx[0]] ? RESP_ON : RESP_OFF;
                end
                OP_QRY_EXT: begin
                  resp_valid_q <= 1'b1;
                  resp_data_q <= ext_en_q ? RESP_ON : RESP_OFF;
                end
                OP_START: begin
                  meas_start_q <= 1'b1;
                  meas_have_q <= 1'b1;
                  deliver_q <= 1'b0;
                  state_q <= MS_WAIT;
                  cmd_ready_q <= 1'b0;
                end
                OP_FETCH: begin
                  if (result_ok_q) begin
                    resp_valid_q <= 1'b1;
                    resp_data_q <= result_q;
                  end else begin
                    err_q <= 1'b1;
                  end
                end
                OP_READ: begin
                  if (!CMD.has_func && !meas_have_q) begin
                    err_q <= 1'b1;
                  end else begin
                    // Start, then fetch once done, after flushing stale words.
                    resp_flush_q <= 1'b1;
                    meas_start_q <= 1'b1;
                    meas_have_q <= 1'b1;
                    deliver_q <= 1'b1;
                    state_q <= MS_WAIT;
                    cmd_ready_q <= 1'b0;
                  end
                end
                default: ;
              endcase
            end
          end
          MS_WAIT: begin
            if (MEAS_DONE) begin
              result_q <= meas_word;
              result_ok_q <= 1'b1;
              resp_valid_q <= deliver_q;
              resp_data_q <= deliver_q ? meas_word : resp_data_q;
              state_q <= MS_IDLE;
              cmd_ready_q <= 1'b1;
            end
          end
          default: begin
            state_q <= MS_IDLE;
            cmd_ready_q <= 1'b1;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output assignments, all straight from flip-flops.

  assign CMD_READY = cmd_ready_q;
  assign TTL_N = ttl_n_q;
  assign ECL = ecl_q;
  assign EXT_N = ext_n_q;
  assign MASTER_EN = master_en_q;
  assign MEAS_START = meas_start_q;
  assign RESP_VALID = resp_valid_q;
  assign RESP_DATA = resp_data_q;
  assign RESP_FLUSH = resp_flush_q;
  assign ERR = err_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions; a frozen clock enable suspends checking.

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST || !CE);

  a_master_blocks_all: assert property (!master_en_q |=> (&ttl_n_q && ecl_q == '0 && ext_n_q))
    else $error("Trigger output active with master enable off.");
  // The pin follows the pulse window through one more register, so master must hold twice.
  a_ttl_pulse_fires: assert property ((trig_accept && ttl_en_q[0] && master_en_q && !SOFT_RST)
      ##1 master_en_q ##1 master_en_q |=> !ttl_n_q[0])
    else $error("Enabled TTL line did not pulse.");
  a_ttl_disabled_quiet: assert property (trig_accept && !ttl_en_q[1] |=> ttl_n_q[1] [*5])
    else $error("Disabled TTL line pulsed.");
  a_ttl_low_pulse: assert property (!ttl_n_q[0] |-> $past(pulse_active))
    else $error("TTL line low outside a pulse.");
  a_pulse_fixed_len: assert property (trig_accept |=> pulse_active [*5] ##1 !pulse_active)
    else $error("Pulse length wrong or retriggered.");
  a_ecl_high_pulse: assert property (ecl_q[0] |-> $past(pulse_active) && $past(master_en_q))
    else $error("ECL line high outside a pulse.");
  a_reset_clears_en: assert property (SOFT_RST |=> (!master_en_q && ttl_en_q == '0
      && ecl_en_q == '0 && !ext_en_q))
    else $error("Instrument reset left an enable on.");
  a_master_query: assert property (cmd_take && state_q == MS_IDLE && CMD.op == OP_QRY_MASTER
      |=> resp_valid_q && resp_data_q == (($past(master_en_q)) ? RESP_ON : RESP_OFF))
    else $error("Master query answer wrong.");
  a_ttl_query: assert property (cmd_take && state_q == MS_IDLE && CMD.op == OP_QRY_TTL
      && ttl_en_q[CMD.idx] |=> resp_valid_q && resp_data_q == RESP_ON)
    else $error("TTL query answer wrong.");
  a_read_flushes: assert property (cmd_take && state_q == MS_IDLE && CMD.op == OP_READ
      && (CMD.has_func || meas_have_q) |=> resp_flush_q && meas_start_q && !cmd_ready_q)
    else $error("Read did not flush and start.");
  a_bare_read_err: assert property (cmd_take && state_q == MS_IDLE && CMD.op == OP_READ
      && !CMD.has_func && !meas_have_q |=> err_q && !meas_start_q)
    else $error("Bare read after reset did not error.");
  a_invalid_sentinel: assert property (state_q == MS_WAIT && MEAS_DONE && !MEAS_VALID
      && deliver_q && !SOFT_RST |=> resp_valid_q && resp_data_q == SENTINEL)
    else $error("Invalid result not replaced by sentinel.");

  c_all_outputs: cover property (!(|ttl_n_q) && (&ecl_q) && !ext_n_q);
  c_read_done: cover property (deliver_q && state_q == MS_WAIT ##1 resp_valid_q);
  c_retrigger: cover property (TRIG_EVENT && pulse_active);
  c_bare_err: cover property (err_q);

endmodule // tor_router

// ### verification/tor_meas_model.sv
/*
  Behavioural measurement engine that answers the router's start strobe.
  Assumes the bench sets delay, validity and result value before each start.
*/
`timescale 1ns/100ps
module tor_meas_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Start from the router and settings from the bench.
  input wire logic start,
  input wire logic ok,
  input wire logic [7:0] dly,
  input wire logic [31:0] value,
  // Answer to the router.
  output logic done,
  output logic valid,
  output logic [31:0] result
);
  logic [7:0] cnt_q;
  logic busy_q;

  // Counts the set delay after a start, then pulses done for one cycle.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_q <= 1'h0;
      cnt_q <= 8'h00;
      done <= 1'h0;
    end else begin
      done <= busy_q && (cnt_q == 8'h00);
      if (start) begin
        busy_q <= 1'h1;
        cnt_q <= dly;
      end else if (busy_q && (cnt_q == 8'h00)) begin
        busy_q <= 1'h0;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end

  // Outside the done cycle the data lines show the inverse, so no stale value passes.
  assign valid = done ? ok : ~ok;
  assign result = done ? value : ~value;
endmodule // tor_meas_model

// ### verification/tor_router_tb.sv
/*
  Self-checking bench of the trigger output router: enables, queries, pulses
  and measurement sequencing. Assumes the measurement model file is compiled first.
*/
`timescale 1ns/100ps
module tor_router_tb import tor_pkg::*;;
  localparam logic [10:0] IDLE = {8'hff, 2'h0, 1'h1};
  logic clk, nrst, ce, cmd_valid, soft_rst, trig_event, ok;
  tor_cmd_s cmd;
  logic [7:0] dly;
  logic [31:0] value;
  logic cmd_ready, master_en, meas_start, meas_done, meas_valid;
  logic resp_valid, resp_flush, err;
  logic [TTL_LINES-1:0] ttl_n;
  logic [ECL_LINES-1:0] ecl;
  logic ext_n;
  logic [31:0] meas_result, resp_data;
  int failures = 0;
  int checks = 0;
  int cycles = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Design and far-side engine.
  tor_router i_dut (.CLK(clk), .NRST(nrst), .CE(ce), .CMD_VALID(cmd_valid), .CMD(cmd),
    .CMD_READY(cmd_ready), .SOFT_RST(soft_rst), .TRIG_EVENT(trig_event), .TTL_N(ttl_n),
    .ECL(ecl), .EXT_N(ext_n), .MASTER_EN(master_en), .MEAS_START(meas_start),
    .MEAS_DONE(meas_done), .MEAS_VALID(meas_valid), .MEAS_RESULT(meas_result),
    .RESP_VALID(resp_valid), .RESP_DATA(resp_data), .RESP_FLUSH(resp_flush), .ERR(err));
  tor_meas_model i_meas (.clk(clk), .nrst(nrst), .start(meas_start), .ok(ok), .dly(dly),
    .value(value), .done(meas_done), .valid(meas_valid), .result(meas_result));

  // Free-running clock and a cycle ceiling against hangs.
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks.
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // One command cycle; returns at the falling edge after the taking edge.
  task automatic send(input logic [3:0] op, input logic [2:0] idx, input logic v,
                      input logic hf);
    @(negedge clk);
    cmd_valid = 1'h1;
    cmd = {op, idx, v, hf};
    @(negedge clk);
    cmd_valid = 1'h0;
  endtask

  task automatic qry(input logic [3:0] op, input logic [2:0] idx, input logic [31:0] exp);
    send(op, idx, 1'h0, 1'h0);
    check("resp_valid", 32'(resp_valid), 32'h1);
    check("resp_data", resp_data, exp);
  endtask

  // Waits a bounded time for a strobe; a strobe stands one cycle.
  task automatic wait_resp();
    for (int k = 0; k < 40 && resp_valid !== 1'h1; k++) @(negedge clk);
  endtask

  // Fires one event held for hold cycles and records the output word each cycle.
  task automatic trig(input int hold, input logic [10:0] act);
    logic [10:0] cur;
    logic [10:0] seen;
    int first;
    int cnt;
    first = 0;
    cnt = 0;
    seen = IDLE;
    @(negedge clk);
    trig_event = 1'h1;
    for (int k = 1; k <= 10; k++) begin
      @(negedge clk);
      if (k == hold) trig_event = 1'h0;
      cur = {ttl_n, ecl, ext_n};
      if (cur !== IDLE) begin
        cnt++;
        if (first == 0) begin
          first = k;
          seen = cur;
        end
      end
    end
    check("pulse word", 32'(seen), 32'(act));
    check("pulse cycles", 32'(cnt), (act === IDLE) ? 32'h0 : 32'h5);
    if (act !== IDLE) check("pulse start", 32'(first), 32'h2);
  endtask

  // Read or start/fetch with the engine answering d+2 cycles after the start strobe.
  task automatic meas(input logic [3:0] op, input logic v, input logic [7:0] d,
                      input logic [31:0] val, input logic [31:0] exp);
    ok = v;
    dly = d;
    value = val;
    send(op, 3'h0, 1'h0, 1'h1);
    check("meas_start", 32'(meas_start), 32'h1);
    check("flush", 32'(resp_flush), (op == OP_READ) ? 32'h1 : 32'h0);
    check("busy", 32'(cmd_ready), 32'h0);
    if (op == OP_START) begin
      for (int k = 0; k < 40 && cmd_ready !== 1'h1; k++) @(negedge clk);
      send(OP_FETCH, 3'h0, 1'h0, 1'h0);
    end else wait_resp();
    check("meas data", resp_data, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence. The clock enable drops once, to show that it freezes the enables.
  initial begin
    {nrst, cmd_valid, soft_rst, trig_event, ok} = 5'h00;
    ce = 1'h1;
    cmd = '0;
    dly = 8'h01;
    value = 32'h0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    nrst = 1'h1;
    check("outs at reset", 32'({ttl_n, ecl, ext_n}), 32'(IDLE));
    check("master at reset", 32'(master_en), 32'h0);
    for (int i = 0; i < 8; i++) qry(OP_QRY_TTL, 3'(i), RESP_OFF);
    qry(OP_QRY_MASTER, 3'h0, RESP_OFF);
    // All single enables on but master off: nothing may pulse.
    for (int i = 0; i < 8; i++) send(OP_SET_TTL, 3'(i), 1'h1, 1'h0);
    send(OP_SET_ECL, 3'h0, 1'h1, 1'h0);
    send(OP_SET_ECL, 3'h1, 1'h1, 1'h0);
    send(OP_SET_EXT, 3'h0, 1'h1, 1'h0);
    trig(1, IDLE);
    send(OP_SET_MASTER, 3'h0, 1'h1, 1'h0);
    check("master on", 32'(master_en), 32'h1);
    trig(1, {8'h00, 2'h3, 1'h0});
    trig(3, {8'h00, 2'h3, 1'h0});
    // Odd TTL lines and ECL line 0 only.
    for (int i = 0; i < 8; i += 2) send(OP_SET_TTL, 3'(i), 1'h0, 1'h0);
    send(OP_SET_ECL, 3'h1, 1'h0, 1'h0);
    send(OP_SET_EXT, 3'h0, 1'h0, 1'h0);
    trig(1, {8'h55, 2'h1, 1'h1});
    for (int i = 0; i < 8; i++) qry(OP_QRY_TTL, 3'(i), i[0] ? RESP_ON : RESP_OFF);
    qry(OP_QRY_MASTER, 3'h0, RESP_ON);
    // With the clock enable low a command must leave the master enable untouched.
    @(negedge clk);
    ce = 1'h0;
    send(OP_SET_MASTER, 3'h0, 1'h0, 1'h0);
    ce = 1'h1;
    check("master frozen", 32'(master_en), 32'h1);
    qry(OP_QRY_ECL, 3'h0, RESP_ON);
    qry(OP_QRY_ECL, 3'h1, RESP_OFF);
    qry(OP_QRY_EXT, 3'h0, RESP_OFF);
    // Measurements: bare read and fetch with no history fail.
    send(OP_READ, 3'h0, 1'h0, 1'h0);
    check("bare read err", 32'(err), 32'h1);
    check("bare read start", 32'(meas_start), 32'h0);
    send(OP_FETCH, 3'h0, 1'h0, 1'h0);
    check("fetch err", 32'(err), 32'h1);
    meas(OP_READ, 1'h1, 8'h01, 32'h1234_5678, 32'h1234_5678);
    meas(OP_READ, 1'h0, 8'h0a, 32'h0bad_0001, SENTINEL);
    meas(OP_START, 1'h1, 8'h03, 32'h0a5a_0c3c, 32'h0a5a_0c3c);
    send(OP_READ, 3'h0, 1'h0, 1'h0);
    check("read err after start", 32'(err), 32'h0);
    wait_resp();
    check("bare read data", resp_data, 32'h0a5a_0c3c);
    // Instrument reset clears every enable and the measurement history.
    @(negedge clk);
    soft_rst = 1'h1;
    @(negedge clk);
    soft_rst = 1'h0;
    check("master after rst", 32'(master_en), 32'h0);
    qry(OP_QRY_TTL, 3'h1, RESP_OFF);
    qry(OP_QRY_ECL, 3'h0, RESP_OFF);
    trig(1, IDLE);
    send(OP_READ, 3'h0, 1'h0, 1'h0);
    check("read err after rst", 32'(err), 32'h1);
    print_verdict();
  end
endmodule // tor_router_tb
